/* File: common/monitor_pkg.sv */
// Purpose: Shared constants and types of the conversion cycle sequencer.
// Assumes: 100 MHz mclk, plain register port with 8-bit address, 16-bit data.
// Notes:   Every offset, reset value and cycle count lives here.
`default_nettype none
package monitor_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS      = 10;
    localparam int SAMPLE_BASE_NS     = 2500000;                        // Shortest sample time, 2.5 ms
    localparam int SAMPLE_BASE_CYCLES = SAMPLE_BASE_NS / CLK_PERIOD_NS;
    localparam int SLOW_PERIOD_NS     = 1000000000;                     // Slowest rate, one per second
    localparam int SLOW_PERIOD_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE       = 3;                              // Edges before strap capture

    // Data widths
    localparam int SHUNT_W    = 12;    // 11 bits plus sign
    localparam int RAIL_W     = 11;    // Unsigned
    localparam int POWER_W    = 16;
    localparam int HIST_DEPTH = 8;     // Deepest averaging window

    // Global register offsets
    localparam logic [7:0] REG_ENABLE      = 8'h00;
    localparam logic [7:0] REG_RATE        = 8'h01;
    localparam logic [7:0] REG_ONE_SHOT    = 8'h02;
    localparam logic [7:0] REG_STATE       = 8'h03;
    localparam logic [7:0] REG_HIGH_STATUS = 8'h04;
    localparam logic [7:0] REG_LOW_STATUS  = 8'h05;
    localparam logic [7:0] REG_ALERT_MASK  = 8'h06;
    localparam logic [7:0] REG_SLAVE_ADDR  = 8'h07;
    // Per-channel block: channel c sits at high nibble CH_BASE_NIB + c
    localparam logic [3:0] CH_BASE_NIB     = 4'h1;
    localparam logic [3:0] CH_CFG          = 4'h0;
    localparam logic [3:0] CH_SHUNT        = 4'h1;
    localparam logic [3:0] CH_RAIL         = 4'h2;
    localparam logic [3:0] CH_POWER        = 4'h3;
    localparam logic [3:0] CH_SHUNT_HI     = 4'h4;
    localparam logic [3:0] CH_SHUNT_LO     = 4'h5;
    localparam logic [3:0] CH_RAIL_HI      = 4'h6;
    localparam logic [3:0] CH_RAIL_LO      = 4'h7;
    localparam int         DONE_BIT        = 7;      // Cycle complete in high status

    // Reset values
    localparam logic [3:0]         ENABLE_RST   = 4'hF;
    localparam logic [1:0]         RATE_RST     = 2'h0;
    localparam logic [1:0]         RATE_CONT    = 2'h3;   // Continuous conversion code
    localparam logic [7:0]         MASK_RST     = 8'h00;
    localparam logic [15:0]        CFG_RST      = 16'h0C65;
    localparam logic [SHUNT_W-1:0] SHUNT_HI_RST = 12'h7FF;
    localparam logic [SHUNT_W-1:0] SHUNT_LO_RST = 12'h800;
    localparam logic [RAIL_W-1:0]  RAIL_HI_RST  = 11'h7FF;
    localparam logic [RAIL_W-1:0]  RAIL_LO_RST  = 11'h000;

    // Per-channel configuration word
    typedef struct packed {
        logic [3:0] spare;        // Reads back, no effect
        logic [1:0] full_scale_range;          // Full scale range, 3 = 80 mV
        logic [1:0] rail_avg;     // Window 1, 2, 4 or 8
        logic [2:0] rail_time;    // 2.5 ms shifted left by code
        logic [1:0] shunt_avg;
        logic [2:0] shunt_time;
    } ch_cfg_s;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_STANDBY  = 4'b0001,
        ST_WAIT     = 4'b0010,
        ST_CONVERT  = 4'b0100,
        ST_ONE_SHOT = 4'b1000
    } seq_state_e;
endpackage : monitor_pkg
`default_nettype wire

/* File: dv/adc_model.sv */
// Purpose: Converter front end model for the sequencer bench
// Assumes: Data is valid only while a phase is sampling
// Notes:   Outside a phase the lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module adc_model import monitor_pkg::*; #(parameter int CHANNELS = 2) (
    input  wire logic                             alt,
    input  wire logic [CHANNELS-1:0]              shunt_sampling,
    input  wire logic [CHANNELS-1:0]              rail_sampling,
    output logic      [CHANNELS-1:0][SHUNT_W-1:0] adc_shunt_sample,
    output logic      [CHANNELS-1:0][RAIL_W-1:0]  adc_rail_sample
);
    // Low bits set so truncation of resolution shows
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            adc_shunt_sample[i] = (alt ? 12'h7EF : 12'h3EF) ^ {SHUNT_W{~shunt_sampling[i]}};
            adc_rail_sample[i]  = (alt ? 11'h2AF : 11'h54F) ^ {RAIL_W{~rail_sampling[i]}};
        end
    end
endmodule : adc_model
`default_nettype wire

/* File: dv/conversion_cycle_sequencer_tb.sv */
// Purpose: Self-checking bench of the sequencer
// Assumes: 4-cycle base sample, 64-cycle second
// Notes:   Model front end gives fixed samples
`timescale 1ns/1ps
`default_nettype none
module conversion_cycle_sequencer_tb import monitor_pkg::*;;
    logic                    mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, alt = 0; // Clock, reset, strobes
    logic [7:0]              reg_addr = '0;                  // Address
    logic [15:0]             reg_wdata = '0, reg_rdata;      // Data
    logic [1:0]              shunt_sampling, rail_sampling;  // Phases
    logic [1:0][SHUNT_W-1:0] sh;                             // Shunt samples
    logic [1:0][RAIL_W-1:0]  ra;                             // Rail samples
    logic                    afe_power_on, alert;            // Cycle, alert
    int                      failures = 0, samples_checked = 0, waited;
    initial forever #5 mclk = ~mclk;
    conversion_cycle_sequencer #(.CHANNELS(2), .SAMPLE_BASE_CY(4), .SECOND_CY(64)) dut (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .addr_strap(3'h5), .adc_shunt_sample(sh), .adc_rail_sample(ra), .shunt_sampling(shunt_sampling),
        .rail_sampling(rail_sampling), .afe_power_on(afe_power_on), .alert(alert));
    adc_model #(.CHANNELS(2)) adc (.alt(alt), .shunt_sampling(shunt_sampling), .rail_sampling(rail_sampling),
        .adc_shunt_sample(sh), .adc_rail_sample(ra));
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask : rd
    // Bounded wait for a cycle level, counting edges
    task automatic wait_afe(input logic v);
        #1;
        repeat (2000) if (afe_power_on !== v) begin
            @(posedge mclk);
            #1 waited++;
        end
    endtask : wait_afe
    // Start to start spacing of the second of two cycles
    task automatic gap(input int lo, input int hi);
        repeat (2) begin
            waited = 0;
            wait_afe(1'b0);
            wait_afe(1'b1);
        end
        cmp(16'(waited >= lo && waited <= hi), 16'h0001);
    endtask : gap
    task automatic t_reset;
        rd(REG_ENABLE, 16'h000F);
        rd(REG_ALERT_MASK, 16'h0000);
        rd(8'h10, CFG_RST);
        rd(8'h25, 16'hF800);
        rd(REG_SLAVE_ADDR, 16'h0005);
        rd(8'h08, 16'h0000);
    endtask : t_reset
    task automatic t_active;
        wr(8'h10, 16'h0C00);
        wr(8'h20, 16'h0C00);
        gap(64, 64);
        wr(REG_RATE, 16'h0002);
        gap(16, 16);
        rd(8'h11, 16'h03E0);
        rd(8'h13, 16'h5160);
        alt <= 1'b1;
        wr(REG_ENABLE, 16'h000D);
        gap(16, 16);
        rd(8'h11, 16'h07E0);
        rd(8'h12, 16'h0540);
        rd(8'h22, 16'h02A0);
        rd(8'h13, 16'hA560);
        wr(8'h10, 16'h0C05);
        wr(REG_RATE, 16'h0000);
        gap(129, 140);
        wr(8'h10, 16'h0C00);
        wr(REG_RATE, 16'h0003);
        gap(10, 10);
    endtask : t_active
    task automatic t_standby;
        wr(REG_ENABLE, 16'h0000);
        repeat (150) @(posedge mclk);
        rd(REG_STATE, 16'h0001);
        wr(8'h14, 16'h0100);
        rd(REG_HIGH_STATUS, 16'h0080);
        wr(REG_ONE_SHOT, 16'h0001);
        wait_afe(1'b1);
        wait_afe(1'b0);
        waited = 0;
        wait_afe(1'b1);
        cmp(16'(waited), 16'd2000);
        rd(8'h12, 16'h02A0);
        rd(REG_STATE, 16'h0001);
        rd(REG_HIGH_STATUS, 16'h0081);
        cmp(16'(alert), 16'h0001);
        rd(REG_HIGH_STATUS, 16'h0001);
        wr(REG_ALERT_MASK, 16'h0001);
        wr(REG_ONE_SHOT, 16'h0001);
        wait_afe(1'b1);
        wait_afe(1'b0);
        cmp(16'(alert), 16'h0000);
        alt <= 1'b0;
        wr(8'h10, 16'h0C08);
        wr(REG_ONE_SHOT, 16'h0001);
        wait_afe(1'b1);
        wait_afe(1'b0);
        rd(8'h11, 16'h05E0);
    endtask : t_standby
    task automatic results;
        if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_active();
        t_standby();
        results();
    end
    // Watchdog well past the expected run
    initial begin
        #300000;
        failures++;
        results();
    end
endmodule : conversion_cycle_sequencer_tb
`default_nettype wire

/* File: dv/sequencer_sva.sv */
// Purpose: Port checks of the conversion cycle sequencer
// Assumes: Bound into every sequencer instance
// Notes:   Channel 0 phases stand for all channels
`timescale 1ns/1ps
`default_nettype none
module sequencer_sva #(parameter int CHANNELS = 2) (
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic                reg_rd,
    input wire logic [15:0]         reg_rdata,
    input wire logic [CHANNELS-1:0] shunt_sampling,
    input wire logic [CHANNELS-1:0] rail_sampling,
    input wire logic                afe_power_on,
    input wire logic                alert
);
    wire logic [CHANNELS-1:0] busy = shunt_sampling | rail_sampling; // Any phase running
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence shunt_min; shunt_sampling[0] [*4]; endsequence // Shortest phase
    phase_excl_a: assert property ((shunt_sampling & rail_sampling) == '0) else $error("phases overlap");
    power_busy_a: assert property (busy != '0 |-> afe_power_on) else $error("sampling while off");
    shunt_first_a: assert property ($rose(shunt_sampling[0]) |-> $rose(afe_power_on)) else $error("no power");
    shunt_len_a: assert property ($rose(shunt_sampling[0]) |-> shunt_min) else $error("shunt phase short");
    end_idle_a: assert property ($fell(afe_power_on) |-> $past(busy) == '0) else $error("early end");
    alert_end_a: assert property ($changed(alert) |-> $fell(afe_power_on)) else $error("alert moved");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("stray read data");
    cycle_end_a: assert property ($rose(afe_power_on) |-> ##[1:1000] !afe_power_on) else $error("no end");
endmodule : sequencer_sva
bind conversion_cycle_sequencer sequencer_sva #(.CHANNELS(CHANNELS)) sva (.mclk(mclk), .rst(rst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shunt_sampling(shunt_sampling), .rail_sampling(rail_sampling),
    .afe_power_on(afe_power_on), .alert(alert));
`default_nettype wire

/* File: logic/conversion_cycle_sequencer.sv */
// Purpose: Sequences conversion cycles, averaging, limits and alert.
// Assumes: Converter samples arrive on the mclk domain; strap pin is async.
// Notes on behaviour
// [R1] Active state repeats cycles at programmed rate
// [R2] Standby runs no cycles, front end off
// [R3] Registers stay readable during standby
// [R4] All enables cleared puts device in standby
// [R5] One-shot request in standby runs one cycle
// [R6] After one-shot cycle return to standby
// [R7] Active cycles skip disabled measurements
// [R8] Standby-started cycle measures everything
// [R9] Channels start their sampling together
// [R10] Shunt sample first, then rail sample
// [R11] Optional averaging over two to eight samples
// [R12] Time and averaging per measurement, per channel
// [R13] Only enabled results written at cycle end
// [R14] Power and both statuses refreshed every cycle
// [R15] Alert on any unmasked out-of-limit result
// [R16] High and low limits for both measurements
// [R17] Mask suppresses alert per limit flag
// [R18] Slowest rate is one per second
// [R19] Sampling longer than period means continuous
// [R20] Resolution six to eleven bits plus sign
// [R21] Slave address taken from address strap
// [R22] Shunt result signed, eleven bits plus sign
// [R23] Power recomputed when either result changes
// [R24] Range defaults to the 80 mV setting
// [R25] Cycle complete stays until status read
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module conversion_cycle_sequencer
    import monitor_pkg::*;
#(
    parameter int CHANNELS       = 2,                   // One or two channels
    parameter int SAMPLE_BASE_CY = SAMPLE_BASE_CYCLES,  // Cycles in 2.5 ms
    parameter int SECOND_CY      = SLOW_PERIOD_CYCLES   // Cycles in one second
) (
    input  wire logic                                mclk,
    input  wire logic                                rst,
    input  wire logic [7:0]                          reg_addr,
    input  wire logic [15:0]                         reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [15:0]                         reg_rdata,
    input  wire logic [2:0]                          addr_strap,
    input  wire logic [CHANNELS-1:0][SHUNT_W-1:0]    adc_shunt_sample,
    input  wire logic [CHANNELS-1:0][RAIL_W-1:0]     adc_rail_sample,
    output logic      [CHANNELS-1:0]                 shunt_sampling,
    output logic      [CHANNELS-1:0]                 rail_sampling,
    output logic                                     afe_power_on,
    output logic                                     alert
);

    // Whole module state
    typedef struct packed {
        seq_state_e                                        st;           // Power state
        logic                                              all_meas;     // Cycle ignores enables
        logic [3:0]                                        enable;       // Bit c*2+k, k=0 shunt
        logic [1:0]                                        rate;         // Period = 1 s >> rate, code 3 continuous
        logic [7:0]                                        mask;         // [3:0] high, [7:4] low
        logic [2:0]                                        strap_s1;     // Synchroniser stage 1
        logic [2:0]                                        strap_s2;     // Synchroniser stage 2
        logic [1:0]                                        strap_age;    // Settle counter
        logic [2:0]                                        slave_addr;   // Captured strap
        logic [31:0]                                       period_cnt;   // Counts to next start
        logic [CHANNELS-1:0]                               ph_rail;      // In rail phase
        logic [CHANNELS-1:0]                               ph_done;      // Channel finished
        logic [CHANNELS-1:0][31:0]                         ph_cnt;       // Phase countdown
        ch_cfg_s [CHANNELS-1:0]                            cfg;
        logic [CHANNELS-1:0][1:0][SHUNT_W-1:0]             smp;          // Samples this cycle
        logic [CHANNELS-1:0][1:0][HIST_DEPTH-1:0][SHUNT_W-1:0] hist;     // Newest at 0
        logic [CHANNELS-1:0][SHUNT_W-1:0]                  shunt_res;
        logic [CHANNELS-1:0][RAIL_W-1:0]                   rail_res;
        logic [CHANNELS-1:0][POWER_W-1:0]                  power;
        logic [CHANNELS-1:0][SHUNT_W-1:0]                  sh_hi;
        logic [CHANNELS-1:0][SHUNT_W-1:0]                  sh_lo;
        logic [CHANNELS-1:0][RAIL_W-1:0]                   rl_hi;
        logic [CHANNELS-1:0][RAIL_W-1:0]                   rl_lo;
        logic [3:0]                                        hi_flag;
        logic [3:0]                                        lo_flag;
        logic                                              done_flag;
        logic                                              alert;
        logic [CHANNELS-1:0]                               sh_smp_o;
        logic [CHANNELS-1:0]                               rl_smp_o;
        logic                                              afe_on;
        logic [15:0]                                       rdata;
    } state_s;

    state_s s_reg;   // Registered state
    state_s s_next;  // Next state

    // Sample time in cycles for a time code
    function automatic logic [31:0] smp_cycles(input logic [2:0] code);
        return 32'(SAMPLE_BASE_CY) << code;
    endfunction : smp_cycles

    // Resolution: 6 magnitude bits at code 0, 11 from code 5 up
    function automatic logic [3:0] drop_bits(input logic [2:0] code);
        return (code >= 3'h5) ? 4'h0 : 4'(3'h5 - code);
    endfunction : drop_bits

    // Average of the newest 1 << avg history entries
    function automatic logic [SHUNT_W-1:0] window_avg(input logic [HIST_DEPTH-1:0][SHUNT_W-1:0] h,
                                                      input logic [1:0] avg);
        logic signed [SHUNT_W+2:0] acc;
        acc = '0;
        for (int d = 0; d < HIST_DEPTH; d++) begin
            if (d < (1 << avg)) begin
                acc = acc + (SHUNT_W+3)'(signed'(h[d]));
            end
        end
        acc = acc >>> avg;
        return acc[SHUNT_W-1:0];
    endfunction : window_avg

    // Next state logic
    always_comb begin
        logic        ch_hit;
        logic [3:0]  ch_idx;
        logic        start;
        logic        finish;
        logic [15:0] rd;
        logic [SHUNT_W-1:0] mag;
        logic [22:0] prod;
        logic        on;
        ch_hit = 1'b0;
        ch_idx = 4'h0;
        start  = 1'b0;
        finish = 1'b0;
        rd     = 16'h0000;
        mag    = '0;
        prod   = '0;
        on     = 1'b0;
        s_next = s_reg;

        // Strap synchroniser and one capture after settling
        s_next.strap_s1 = addr_strap;
        s_next.strap_s2 = s_reg.strap_s1;
        if (s_reg.strap_age != 2'(STRAP_SETTLE)) begin
            s_next.strap_age = s_reg.strap_age + 2'h1;
            if (s_reg.strap_age == 2'(STRAP_SETTLE - 1)) begin
                s_next.slave_addr = s_reg.strap_s2;  // [R21]
            end
        end

        // Decode of per-channel window
        if (reg_addr[7:4] >= CH_BASE_NIB && reg_addr[7:4] < CH_BASE_NIB + 4'(CHANNELS)
            && reg_addr[3:0] <= CH_RAIL_LO) begin
            ch_hit = 1'b1;
            ch_idx = reg_addr[7:4] - CH_BASE_NIB;
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                REG_ENABLE:     s_next.enable = reg_wdata[3:0];
                REG_RATE:       s_next.rate   = reg_wdata[1:0];
                REG_ALERT_MASK: s_next.mask   = reg_wdata[7:0];  // [R17]
                default: begin
                    if (ch_hit) begin
                        case (reg_addr[3:0])
                            CH_CFG:      s_next.cfg[ch_idx]   = ch_cfg_s'(reg_wdata);  // [R12]
                            CH_SHUNT_HI: s_next.sh_hi[ch_idx] = reg_wdata[SHUNT_W-1:0];  // [R16]
                            CH_SHUNT_LO: s_next.sh_lo[ch_idx] = reg_wdata[SHUNT_W-1:0];
                            CH_RAIL_HI:  s_next.rl_hi[ch_idx] = reg_wdata[RAIL_W-1:0];
                            CH_RAIL_LO:  s_next.rl_lo[ch_idx] = reg_wdata[RAIL_W-1:0];
                            default:     ;  // Results are read only
                        endcase
                    end
                end
            endcase
        end

        // Register reads, answered in every state
        case (reg_addr)  // [R3]
            REG_ENABLE:      rd = {12'h000, s_reg.enable};
            REG_RATE:        rd = {14'h0000, s_reg.rate};
            REG_STATE:       rd = {12'h000, s_reg.st};
            REG_HIGH_STATUS: rd = {8'h00, s_reg.done_flag, 3'h0, s_reg.hi_flag};
            REG_LOW_STATUS:  rd = {12'h000, s_reg.lo_flag};
            REG_ALERT_MASK:  rd = {8'h00, s_reg.mask};
            REG_SLAVE_ADDR:  rd = {13'h0000, s_reg.slave_addr};
            default: begin
                if (ch_hit) begin
                    case (reg_addr[3:0])
                        CH_CFG:      rd = s_reg.cfg[ch_idx];
                        CH_SHUNT:    rd = {{4{s_reg.shunt_res[ch_idx][SHUNT_W-1]}}, s_reg.shunt_res[ch_idx]};  // [R22]
                        CH_RAIL:     rd = {5'h00, s_reg.rail_res[ch_idx]};
                        CH_POWER:    rd = s_reg.power[ch_idx];
                        CH_SHUNT_HI: rd = {{4{s_reg.sh_hi[ch_idx][SHUNT_W-1]}}, s_reg.sh_hi[ch_idx]};
                        CH_SHUNT_LO: rd = {{4{s_reg.sh_lo[ch_idx][SHUNT_W-1]}}, s_reg.sh_lo[ch_idx]};
                        CH_RAIL_HI:  rd = {5'h00, s_reg.rl_hi[ch_idx]};
                        CH_RAIL_LO:  rd = {5'h00, s_reg.rl_lo[ch_idx]};
                        default:     rd = 16'h0000;
                    endcase
                end
            end
        endcase
        s_next.rdata = reg_rd ? rd : 16'h0000;

        // Reading high status clears cycle complete; a set below wins
        if (reg_rd && reg_addr == REG_HIGH_STATUS) begin
            s_next.done_flag = 1'b0;  // [R25]
        end

        // Period countdown toward the next start
        if (s_reg.period_cnt != 32'h0000_0000) begin
            s_next.period_cnt = s_reg.period_cnt - 32'h0000_0001;
        end

        // Power state machine
        case (s_reg.st)
            ST_STANDBY: begin
                if (s_reg.enable != 4'h0) begin
                    s_next.st         = ST_WAIT;
                    s_next.period_cnt = 32'h0000_0000;
                end else if (reg_wr && reg_addr == REG_ONE_SHOT) begin
                    start           = 1'b1;  // [R5]
                    s_next.all_meas = 1'b1;  // [R8]
                    s_next.st       = ST_ONE_SHOT;
                end
            end
            ST_WAIT: begin
                if (s_reg.enable == 4'h0) begin
                    s_next.st = ST_STANDBY;  // [R4]
                end else if (s_reg.period_cnt == 32'h0000_0000) begin
                    start           = 1'b1;  // [R1]
                    s_next.all_meas = 1'b0;
                    s_next.st       = ST_CONVERT;
                end
            end
            ST_CONVERT, ST_ONE_SHOT: begin
                // Each channel: shunt phase, then rail phase
                for (int c = 0; c < CHANNELS; c++) begin
                    if (!s_reg.ph_done[c]) begin
                        if (s_reg.ph_cnt[c] != 32'h0000_0000) begin
                            s_next.ph_cnt[c] = s_reg.ph_cnt[c] - 32'h0000_0001;
                        end else if (!s_reg.ph_rail[c]) begin
                            if (s_reg.all_meas || s_reg.enable[c*2]) begin
                                s_next.smp[c][0] = adc_shunt_sample[c]
                                    & ~((SHUNT_W'(1) << drop_bits(s_reg.cfg[c].shunt_time)) - SHUNT_W'(1));  // [R20]
                            end
                            on = s_reg.all_meas || s_reg.enable[c*2+1];
                            s_next.ph_rail[c] = 1'b1;  // [R10]
                            s_next.ph_cnt[c]  = on ? smp_cycles(s_reg.cfg[c].rail_time) - 32'h0000_0001
                                                   : 32'h0000_0000;
                        end else begin
                            if (s_reg.all_meas || s_reg.enable[c*2+1]) begin
                                s_next.smp[c][1] = {1'b0, adc_rail_sample[c]
                                    & ~((RAIL_W'(1) << drop_bits(s_reg.cfg[c].rail_time)) - RAIL_W'(1))};
                            end
                            s_next.ph_done[c] = 1'b1;
                        end
                    end
                end
                if (&s_reg.ph_done) begin
                    finish = 1'b1;
                    if (s_reg.st == ST_ONE_SHOT || s_reg.enable == 4'h0) begin
                        s_next.st = ST_STANDBY;  // [R6]
                    end else begin
                        s_next.st = ST_WAIT;  // [R19]
                    end
                end
            end
            default: s_next.st = ST_STANDBY;
        endcase

        // Cycle start: all channels at once, disabled phases load a zero count and last one cycle
        if (start) begin
            s_next.period_cnt = (s_reg.rate == RATE_CONT) ? 32'h0000_0000
                                : (32'(SECOND_CY) >> s_reg.rate) - 32'h0000_0001;  // [R18]
            for (int c = 0; c < CHANNELS; c++) begin
                on = s_next.all_meas || s_reg.enable[c*2];
                s_next.ph_rail[c] = 1'b0;  // [R9]
                s_next.ph_done[c] = 1'b0;
                s_next.ph_cnt[c]  = on ? smp_cycles(s_reg.cfg[c].shunt_time) - 32'h0000_0001
                                       : 32'h0000_0000;  // [R7]
            end
        end

        // Cycle end: results, power, limits, alert
        if (finish) begin
            for (int c = 0; c < CHANNELS; c++) begin
                for (int k = 0; k < 2; k++) begin
                    if (s_reg.all_meas || s_reg.enable[c*2+k]) begin  // [R13]
                        s_next.hist[c][k] = {s_reg.hist[c][k][HIST_DEPTH-2:0], s_reg.smp[c][k]};
                    end
                end
                if (s_reg.all_meas || s_reg.enable[c*2]) begin
                    s_next.shunt_res[c] = window_avg(s_next.hist[c][0], s_reg.cfg[c].shunt_avg);  // [R11]
                end
                if (s_reg.all_meas || s_reg.enable[c*2+1]) begin
                    s_next.rail_res[c] = RAIL_W'(window_avg(s_next.hist[c][1], s_reg.cfg[c].rail_avg));
                end
                // Magnitude product, saturated to 16 bits
                mag  = s_next.shunt_res[c][SHUNT_W-1] ? SHUNT_W'(-s_next.shunt_res[c]) : s_next.shunt_res[c];
                prod = 23'(mag) * 23'(s_next.rail_res[c]);
                s_next.power[c] = prod[22] ? 16'hFFFF : prod[21:6];  // [R23]
                s_next.hi_flag[c*2]   = $signed(s_next.shunt_res[c]) > $signed(s_reg.sh_hi[c]);  // [R14]
                s_next.lo_flag[c*2]   = $signed(s_next.shunt_res[c]) < $signed(s_reg.sh_lo[c]);
                s_next.hi_flag[c*2+1] = s_next.rail_res[c] > s_reg.rl_hi[c];
                s_next.lo_flag[c*2+1] = s_next.rail_res[c] < s_reg.rl_lo[c];
            end
            s_next.done_flag = 1'b1;  // [R25]
            s_next.alert = |((s_next.hi_flag & ~s_reg.mask[3:0])
                           | (s_next.lo_flag & ~s_reg.mask[7:4]));  // [R15]
        end

        // Front end phase indications
        s_next.afe_on = (s_next.st == ST_CONVERT) || (s_next.st == ST_ONE_SHOT);  // [R2]
        for (int c = 0; c < CHANNELS; c++) begin
            s_next.sh_smp_o[c] = s_next.afe_on && !s_next.ph_done[c] && !s_next.ph_rail[c]
                                 && (s_next.all_meas || s_next.enable[c*2]);
            s_next.rl_smp_o[c] = s_next.afe_on && !s_next.ph_done[c] && s_next.ph_rail[c]
                                 && (s_next.all_meas || s_next.enable[c*2+1]);
        end
    end

    // State register with synchronous reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg            <= '0;
            s_reg.st         <= ST_STANDBY;
            s_reg.enable     <= ENABLE_RST;
            s_reg.rate       <= RATE_RST;
            s_reg.mask       <= MASK_RST;
            s_reg.ph_done    <= '1;
            for (int c = 0; c < CHANNELS; c++) begin
                s_reg.cfg[c]   <= ch_cfg_s'(CFG_RST);  // [R24]
                s_reg.sh_hi[c] <= SHUNT_HI_RST;
                s_reg.sh_lo[c] <= SHUNT_LO_RST;
                s_reg.rl_hi[c] <= RAIL_HI_RST;
                s_reg.rl_lo[c] <= RAIL_LO_RST;
            end
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state flops
    assign reg_rdata      = s_reg.rdata;
    assign shunt_sampling = s_reg.sh_smp_o;
    assign rail_sampling  = s_reg.rl_smp_o;
    assign afe_power_on   = s_reg.afe_on;
    assign alert          = s_reg.alert;

endmodule : conversion_cycle_sequencer
`default_nettype wire
